// *** src/plsc_pkg.sv ***
// Purpose: Shared constants and types for the programmable logic slice cluster.
// Assumes: One system clock; configuration inputs are static outside configuration.
// Notes:   Routing input and output bit positions are fixed here for all slices.

package plsc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_SLICES  = 4;
  localparam int NUM_TABLES  = 8;
  localparam int TABLE_DEPTH = 16;
  localparam int TABLE_AW    = 4;
  localparam int ROUTE_IN_W  = 15;
  localparam int ROUTE_OUT_W = 6;
  localparam int RAM_CTRL    = 2;
  localparam int RAM_WIDTH   = 4;

  // ---------------------------------------------------------------------------
  // Routing input bit positions of one slice
  // ---------------------------------------------------------------------------
  localparam int IN_T0_LSB = 0;
  localparam int IN_T1_LSB = 4;
  localparam int IN_SEL    = 8;
  localparam int IN_OP     = 9;
  localparam int IN_CLK0   = 10;
  localparam int IN_CLK1   = 11;
  localparam int IN_LSR    = 12;
  localparam int IN_CS     = 13;
  localparam int IN_LOAD   = 14;

  // ---------------------------------------------------------------------------
  // Routing output bit positions of one slice
  // ---------------------------------------------------------------------------
  localparam int OUT_F0 = 0;
  localparam int OUT_F1 = 1;
  localparam int OUT_Q0 = 2;
  localparam int OUT_Q1 = 3;
  localparam int OUT_X0 = 4;
  localparam int OUT_X1 = 5;

  // ---------------------------------------------------------------------------
  // Modes and types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LOGIC  = 2'b00,
    MODE_RIPPLE = 2'b01,
    MODE_RAM    = 2'b10,
    MODE_ROM    = 2'b11
  } plsc_mode_e;

  typedef enum logic [2:0] {
    OP_ADD     = 3'b000,
    OP_SUB     = 3'b001,
    OP_ADDSUB  = 3'b010,
    OP_CNT_UP  = 3'b011,
    OP_CNT_DN  = 3'b100,
    OP_CNT_UD  = 3'b101,
    OP_COMPARE = 3'b110,
    OP_MULT    = 3'b111
  } plsc_rip_e;

  typedef struct packed {
    plsc_mode_e mode;
    plsc_rip_e  op;
    logic       fast_carry;
    logic       clk_sel;
    logic       clk_neg;
    logic       latch;
    logic       sr_async;
    logic       sr_set;
  } plsc_slice_cfg_s;

  typedef struct packed {
    logic [1:0] s;
    logic       co;
    logic       g;
    logic       p;
  } plsc_rip_s;

  typedef struct packed {
    logic [NUM_TABLES-1:0][TABLE_DEPTH-1:0]  tbl;
    logic [NUM_SLICES-1:0][1:0]              q;
    logic [NUM_SLICES-1:0]                   lvl;
    logic [NUM_SLICES-1:0][ROUTE_OUT_W-1:0]  outs;
    logic                                    cout;
  } plsc_state_s;

  localparam plsc_state_s STATE_RESET = '0;

endpackage

// *** src/plsc_logic_cluster.sv ***
// Purpose: Cluster of four logic slices with tables, registers, carry chain and distributed memory.
// Assumes: Routing and configuration inputs come from logic on clk_sys_in; no synchronisers needed.
// Notes:   Local clocks are routed levels sampled on clk_sys_in; edges and latches are emulated.
//          Slice three treats a RAM request as logic.
//          Latch mode follows the level while it is high.
//          Wide functions chain through the x1 outputs.

`timescale 1ns/1ps

// Summary of operation
// - Four slices, each with two four-input tables feeding two registers.
// - Slices zero to two may be RAM; slice three never becomes RAM.
// - Control gives sync or async set/reset, clock select, chip select, wide memory.
// - Each register has selectable clock polarity and flip-flop or latch behaviour.
// - Each slice takes fifteen routing inputs plus carry in; drives six outputs plus carry.
// - Logic mode: each table returns its programmed bit for the sixteen input codes.
// - Two tables of one slice combine into a five-input function.
// - Six, seven, eight input functions chain slices; eight inputs need another cluster.
// - Ripple mode adds, subtracts, dynamically adds or subtracts, counts up or down.
// - Up/down counters offer asynchronous clear and synchronous preload.
// - Ripple compare yields greater-or-equal, not-equal, less-or-equal; multiplier step too.
// - Fast carry option gives per-slice carry generate and propagate.
// - RAM mode: four tables of slices zero and one form sixteen by four memory.
// - Slice two supplies RAM address and write control.
// - Single-port and pseudo dual-port sixteen by four RAM each use three slices.
// - RAM contents take initial values loaded during configuration.
// - Every slice supports ROM; contents load only during configuration.
module plsc_logic_cluster (
  input  wire logic                                                 clk_sys_in,
  input  wire logic                                                 resetn_in,
  // Table loading.
  input  wire logic                                                 cfg_load_en_in,
  input  wire logic                                                 cfg_wr_in,
  input  wire logic [2:0]                                           cfg_addr_in,
  input  wire logic [plsc_pkg::TABLE_DEPTH-1:0]                     cfg_data_in,
  // Static configuration.
  input  wire plsc_pkg::plsc_slice_cfg_s [plsc_pkg::NUM_SLICES-1:0] slice_cfg_in,
  input  wire logic                                                 ram_dual_in,
  // Routing and carry links.
  input  wire logic [plsc_pkg::NUM_SLICES-1:0][plsc_pkg::ROUTE_IN_W-1:0] route_in,
  input  wire logic                                                 carry_in,
  // Registered results.
  output logic [plsc_pkg::NUM_SLICES-1:0][plsc_pkg::ROUTE_OUT_W-1:0] route_out,
  output logic                                                      carry_out
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // One function keeps the mode rule in one place.
  // Slice three has no write path into its tables, so a RAM request falls back to logic.
  function automatic plsc_pkg::plsc_mode_e eff_mode(input int idx, input plsc_pkg::plsc_mode_e m);
    eff_mode = m;

    if (idx == plsc_pkg::NUM_SLICES - 1 && m == plsc_pkg::MODE_RAM) begin
      eff_mode = plsc_pkg::MODE_LOGIC;
    end
  endfunction

  // Two-bit ripple cell; the operand choice gives every arithmetic flavour one adder.
  function automatic plsc_pkg::plsc_rip_s ripple(input plsc_pkg::plsc_rip_e op,
                                                 input logic [1:0] x,
                                                 input logic [1:0] y,
                                                 input logic [1:0] q,
                                                 input logic dyn,
                                                 input logic cin);
    logic [1:0] pa;
    logic [1:0] pb;
    logic [2:0] sum;
    logic [2:0] sum0;
    logic [2:0] sum1;

    pa = x;
    pb = y;

    // Subtract adds the inverse; carry in adds one.
    unique case (op)
      plsc_pkg::OP_ADD:     pb = y;
      plsc_pkg::OP_SUB:     pb = ~y;
      plsc_pkg::OP_ADDSUB:  pb = dyn ? ~y : y;
      plsc_pkg::OP_CNT_UP: begin
        pa = q;
        pb = 2'h0;
      end
      plsc_pkg::OP_CNT_DN: begin
        pa = q;
        pb = 2'h3;
      end
      plsc_pkg::OP_CNT_UD: begin
        pa = q;
        pb = dyn ? 2'h0 : 2'h3;
      end
      plsc_pkg::OP_COMPARE: pb = ~y;
      plsc_pkg::OP_MULT:    pb = y & {2{dyn}};
    endcase

    // Generate: carry out with no carry in.
    // Propagate: carry only when one comes in.
    sum  = {1'b0, pa} + {1'b0, pb} + {2'h0, cin};
    sum0 = {1'b0, pa} + {1'b0, pb};
    sum1 = {1'b0, pa} + {1'b0, pb} + 3'h1;
    ripple.s  = sum[1:0];
    ripple.co = sum[2];
    ripple.g  = sum0[2];
    ripple.p  = sum1[2] & ~sum0[2];
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // Registered state and its next value.
  plsc_pkg::plsc_state_s                st_r;
  plsc_pkg::plsc_state_s                st_nxt;

  // Working values of the slice loop.
  plsc_pkg::plsc_mode_e                 mode_v [plsc_pkg::NUM_SLICES];
  plsc_pkg::plsc_rip_s                  rip_v;
  logic [plsc_pkg::NUM_SLICES-1:0]      cap_v;
  logic [plsc_pkg::NUM_SLICES-1:0]      x0_v;
  logic [plsc_pkg::ROUTE_IN_W-1:0]      rin;
  logic [plsc_pkg::TABLE_AW-1:0]        a0;
  logic [plsc_pkg::TABLE_AW-1:0]        a1;

  // Shared memory port.
  logic [plsc_pkg::TABLE_AW-1:0]        waddr;
  logic [plsc_pkg::TABLE_AW-1:0]        raddr;
  logic [plsc_pkg::RAM_WIDTH-1:0]       wdata;

  // Ripple operands and register data.
  logic [1:0]                           xa;
  logic [1:0]                           xb;
  logic [1:0]                           dval;
  logic [1:0]                           srv;

  // Table bits and flags.
  logic                                 t0;
  logic                                 t1;
  logic                                 lvl;
  logic                                 ne;

  // Chain carry and mode flags.
  logic                                 carry;
  logic                                 ram_on;
  logic                                 counting;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Slices are evaluated in chain order so the carry ripples 0 to 3 in one cycle.
  always_comb begin
    st_nxt = st_r;
    carry  = carry_in;
    rip_v  = '0;
    cap_v  = '0;
    x0_v   = '0;

    for (int i = 0; i < plsc_pkg::NUM_SLICES; i++) begin
      mode_v[i] = eff_mode(i, slice_cfg_in[i].mode);
    end

    // The memory exists only when both storage slices and the control slice agree.
    ram_on = (mode_v[0] == plsc_pkg::MODE_RAM) && (mode_v[1] == plsc_pkg::MODE_RAM) &&
             (mode_v[plsc_pkg::RAM_CTRL] == plsc_pkg::MODE_RAM);
    waddr  = route_in[plsc_pkg::RAM_CTRL][plsc_pkg::IN_T0_LSB +: plsc_pkg::TABLE_AW];
    // Single port reads where it writes.
    raddr  = ram_dual_in ? route_in[plsc_pkg::RAM_CTRL][plsc_pkg::IN_T1_LSB +: plsc_pkg::TABLE_AW]
                         : waddr;
    // Data from the select and op inputs.
    wdata  = {route_in[1][plsc_pkg::IN_OP], route_in[1][plsc_pkg::IN_SEL],
              route_in[0][plsc_pkg::IN_OP], route_in[0][plsc_pkg::IN_SEL]};

    for (int i = 0; i < plsc_pkg::NUM_SLICES; i++) begin
      rin = route_in[i];

      // Clock select, polarity and edge or level capture, gated by chip select.
      lvl = (slice_cfg_in[i].clk_sel ? rin[plsc_pkg::IN_CLK1] : rin[plsc_pkg::IN_CLK0])
            ^ slice_cfg_in[i].clk_neg;
      cap_v[i] = (slice_cfg_in[i].latch ? lvl : (lvl & ~st_r.lvl[i])) & rin[plsc_pkg::IN_CS];
      // Kept so each edge is seen once.
      st_nxt.lvl[i] = lvl;

      // Storage slices read the shared memory address instead of their own inputs.
      if (ram_on && i < plsc_pkg::RAM_CTRL) begin
        a0 = raddr;
        a1 = raddr;
      end else begin
        a0 = rin[plsc_pkg::IN_T0_LSB +: plsc_pkg::TABLE_AW];
        a1 = rin[plsc_pkg::IN_T1_LSB +: plsc_pkg::TABLE_AW];
      end

      t0 = st_r.tbl[i*2][a0];
      t1 = st_r.tbl[i*2+1][a1];

      xa    = {rin[plsc_pkg::IN_T1_LSB], rin[plsc_pkg::IN_T0_LSB]};
      xb    = {rin[plsc_pkg::IN_T1_LSB+1], rin[plsc_pkg::IN_T0_LSB+1]};

      rip_v = ripple(slice_cfg_in[i].op, xa, xb, st_r.q[i], rin[plsc_pkg::IN_OP], carry);
      // Select chains the lower slice's not-equal.
      ne    = (xa != xb) | rin[plsc_pkg::IN_SEL];

      // Counters take their operand from q.
      counting = (slice_cfg_in[i].op == plsc_pkg::OP_CNT_UP) ||
                 (slice_cfg_in[i].op == plsc_pkg::OP_CNT_DN) ||
                 (slice_cfg_in[i].op == plsc_pkg::OP_CNT_UD);

      // Ripple output map; other modes use tables.
      if (mode_v[i] == plsc_pkg::MODE_RIPPLE) begin
        carry = rip_v.co;
        dval  = (counting && rin[plsc_pkg::IN_LOAD]) ? xa : rip_v.s;
        if (slice_cfg_in[i].op == plsc_pkg::OP_COMPARE) begin
          // Less-or-equal is derived; no second adder.
          st_nxt.outs[i][plsc_pkg::OUT_F0] = rip_v.co;
          st_nxt.outs[i][plsc_pkg::OUT_F1] = ne;
          st_nxt.outs[i][plsc_pkg::OUT_X0] = ~(rip_v.co & ne);
          st_nxt.outs[i][plsc_pkg::OUT_X1] = 1'b0;
        end else begin
          st_nxt.outs[i][plsc_pkg::OUT_F0] = rip_v.s[0];
          st_nxt.outs[i][plsc_pkg::OUT_F1] = rip_v.s[1];
          st_nxt.outs[i][plsc_pkg::OUT_X0] = slice_cfg_in[i].fast_carry & rip_v.g;
          st_nxt.outs[i][plsc_pkg::OUT_X1] = slice_cfg_in[i].fast_carry & rip_v.p;
        end
      end else begin
        dval     = {t1, t0};
        // Select picks a table: five inputs.
        x0_v[i]  = rin[plsc_pkg::IN_SEL] ? t1 : t0;
        st_nxt.outs[i][plsc_pkg::OUT_F0] = t0;
        st_nxt.outs[i][plsc_pkg::OUT_F1] = t1;
        st_nxt.outs[i][plsc_pkg::OUT_X0] = x0_v[i];
        st_nxt.outs[i][plsc_pkg::OUT_X1] = 1'b0;
      end

      // Asynchronous set/reset acts on any cycle; synchronous waits for the capture event.
      // A held set/reset pins the register.
      srv = slice_cfg_in[i].sr_set ? 2'h3 : 2'h0;
      if (rin[plsc_pkg::IN_LSR] && slice_cfg_in[i].sr_async) begin
        st_nxt.q[i] = srv;
      end else if (cap_v[i]) begin
        st_nxt.q[i] = rin[plsc_pkg::IN_LSR] ? srv : dval;
      end

      st_nxt.outs[i][plsc_pkg::OUT_Q0] = st_nxt.q[i][0];
      st_nxt.outs[i][plsc_pkg::OUT_Q1] = st_nxt.q[i][1];
    end

    // Wide functions: pairs give six inputs, slice two joins both pairs for seven,
    // and slice two offers the seven-input result to the next cluster for eight.
    if (mode_v[1] == plsc_pkg::MODE_LOGIC) begin
      st_nxt.outs[1][plsc_pkg::OUT_X1] = route_in[1][plsc_pkg::IN_OP] ? x0_v[1] : x0_v[0];
    end

    if (mode_v[3] == plsc_pkg::MODE_LOGIC) begin
      st_nxt.outs[3][plsc_pkg::OUT_X1] = route_in[3][plsc_pkg::IN_OP] ? x0_v[3] : x0_v[2];
    end

    if (mode_v[2] == plsc_pkg::MODE_LOGIC) begin
      st_nxt.outs[2][plsc_pkg::OUT_X1] = route_in[2][plsc_pkg::IN_OP] ?
                                         st_nxt.outs[3][plsc_pkg::OUT_X1] :
                                         st_nxt.outs[1][plsc_pkg::OUT_X1];
    end

    // The chain leaves through a register.
    st_nxt.cout = carry;

    // Memory write on the control slice's capture event; only tables 0 to 3 are reachable.
    if (ram_on && cap_v[plsc_pkg::RAM_CTRL] && route_in[plsc_pkg::RAM_CTRL][plsc_pkg::IN_SEL]) begin
      for (int k = 0; k < plsc_pkg::RAM_WIDTH; k++) begin
        st_nxt.tbl[k][waddr] = wdata[k];
      end
    end

    // Placed last so it wins over a RAM write.
    // Configuration preload fills RAM initial values and ROM contents alike.
    if (cfg_load_en_in && cfg_wr_in) begin
      st_nxt.tbl[cfg_addr_in] = cfg_data_in;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // One struct keeps every flop in one process.
  // Synchronous reset clears registers and tables; configuration must follow reset.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      st_r <= plsc_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Plain flop outputs, no logic after.
  assign route_out = st_r.outs;
  assign carry_out = st_r.cout;

endmodule

// *** tb/plsc_carry_nbr.sv ***
// Purpose: Neighbouring cluster on the carry chain that feeds the carry input.
// Assumes: The bench sets the requested carry level at the falling clock edge.
// Notes:   Slow mode hands the level over one clock later, as a distant neighbour would.
`timescale 1ns/1ps
module plsc_carry_nbr (
  input  wire logic clk_sys_in,
  input  wire logic carry_req_in,
  input  wire logic slow_in,
  output logic      carry_out
);
  logic stage_r;
  // A registered stage gives the late answer without a second clock.
  always_ff @(posedge clk_sys_in) begin
    stage_r <= carry_req_in;
  end
  assign carry_out = slow_in ? stage_r : carry_req_in;
endmodule

// *** tb/plsc_logic_cluster_asserts.sv ***
// Purpose: Port-level checker for slice zero of the logic cluster.
// Assumes: One clock; synchronous active-low reset clears the tables.
// Notes:   A table shadow follows configuration writes only, so it is valid outside RAM mode.
`timescale 1ns/1ps
module plsc_logic_cluster_asserts (
  input wire logic                                                 clk_sys_in,
  input wire logic                                                 resetn_in,
  input wire logic                                                 cfg_load_en_in,
  input wire logic                                                 cfg_wr_in,
  input wire logic [2:0]                                           cfg_addr_in,
  input wire logic [plsc_pkg::TABLE_DEPTH-1:0]                     cfg_data_in,
  input wire plsc_pkg::plsc_slice_cfg_s [plsc_pkg::NUM_SLICES-1:0] slice_cfg_in,
  input wire logic                                                 ram_dual_in,
  input wire logic [plsc_pkg::NUM_SLICES-1:0][plsc_pkg::ROUTE_IN_W-1:0] route_in,
  input wire logic                                                 carry_in,
  input wire logic [plsc_pkg::NUM_SLICES-1:0][plsc_pkg::ROUTE_OUT_W-1:0] route_out,
  input wire logic                                                 carry_out
);
  logic [7:0][15:0]          sh_r;
  logic [1:0]                a0, b0, lk;
  logic [2:0]                add_v, sub_v;
  logic                      lgc, rip, no_rip;
  plsc_pkg::plsc_slice_cfg_s c0;
  // Operands and expected table outputs of slice zero.
  assign c0     = slice_cfg_in[0];
  assign a0     = {route_in[0][4], route_in[0][0]};
  assign b0     = {route_in[0][5], route_in[0][1]};
  assign lk     = {sh_r[1][route_in[0][7:4]], sh_r[0][route_in[0][3:0]]};
  assign add_v  = {1'b0, a0} + {1'b0, b0} + {2'b00, carry_in};
  assign sub_v  = {1'b0, a0} + {1'b0, ~b0} + {2'b00, carry_in};
  assign lgc    = c0.mode == plsc_pkg::MODE_LOGIC;
  assign rip    = c0.mode == plsc_pkg::MODE_RIPPLE;
  assign no_rip = slice_cfg_in[0].mode != plsc_pkg::MODE_RIPPLE && slice_cfg_in[1].mode != plsc_pkg::MODE_RIPPLE
                  && slice_cfg_in[2].mode != plsc_pkg::MODE_RIPPLE && slice_cfg_in[3].mode != plsc_pkg::MODE_RIPPLE;
  // Shadow of the tables; reset clears them just as it clears the cluster.
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sh_r <= '0;
    end else if (cfg_load_en_in && cfg_wr_in) begin
      sh_r[cfg_addr_in] <= cfg_data_in;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Rising local clock of slice zero, plain positive edge flip-flop.
  sequence s_rise;
    !route_in[0][10] ##1 route_in[0][10] && route_in[0][13] && !c0.latch && !c0.clk_neg && !c0.clk_sel;
  endsequence
  sequence s_cap;
    s_rise ##0 !route_in[0][12] && lgc;
  endsequence
  sequence s_set;
    s_rise ##0 route_in[0][12] && c0.sr_set && !c0.sr_async;
  endsequence
  a_table_lookup: assert property (lgc |=> route_out[0][1:0] == $past(lk))
    else $error("table output wrong");
  a_five_input: assert property (lgc |=> route_out[0][4] ==
    ($past(route_in[0][8]) ? route_out[0][1] : route_out[0][0]))
    else $error("five input select wrong");
  a_ripple_add: assert property (rip && c0.op == plsc_pkg::OP_ADD |=> route_out[0][1:0] == $past(add_v[1:0]))
    else $error("sum wrong");
  a_ripple_sub: assert property (rip && c0.op == plsc_pkg::OP_SUB |=> route_out[0][1:0] == $past(sub_v[1:0]))
    else $error("difference wrong");
  a_compare_flags: assert property (rip && c0.op == plsc_pkg::OP_COMPARE && carry_in
    |=> route_out[0][0] == $past(a0 >= b0) && route_out[0][4] == $past(a0 <= b0))
    else $error("compare flags wrong");
  a_fast_off: assert property (rip && c0.op == plsc_pkg::OP_ADD && !c0.fast_carry
    |=> route_out[0][5:4] == 2'b00)
    else $error("carry helpers not zero");
  a_carry_pass: assert property (no_rip |=> carry_out == $past(carry_in))
    else $error("carry not passed");
  a_edge_capture: assert property (s_cap |=> route_out[0][3:2] == $past(lk))
    else $error("register missed edge");
  a_reg_hold: assert property (!route_in[0][13] && !route_in[0][12] && !c0.sr_async
    |=> $stable(route_out[0][3:2]))
    else $error("register changed without select");
  a_sync_set: assert property (s_set |=> route_out[0][3:2] == 2'b11)
    else $error("sync set failed");
endmodule
bind plsc_logic_cluster plsc_logic_cluster_asserts u_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .cfg_load_en_in(cfg_load_en_in), .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_data_in(cfg_data_in),
  .slice_cfg_in(slice_cfg_in), .ram_dual_in(ram_dual_in), .route_in(route_in), .carry_in(carry_in),
  .route_out(route_out), .carry_out(carry_out));

// *** tb/plsc_logic_cluster_bench.sv ***
// Purpose: Self-checking bench for the logic cluster.
// Assumes: Inputs change at the falling edge; outputs are read one clock later, at the next falling edge.
// Notes:   Memory tests run last because they rewrite the tables.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module plsc_logic_cluster_bench;
  logic                                  clk_sys_in = 1'b0;
  logic                                  resetn_in = 1'b0;
  logic                                  cfg_en = 1'b0;
  logic                                  cfg_wr = 1'b0;
  logic [2:0]                            cfg_addr = 3'h0;
  logic [15:0]                           cfg_data = 16'h0000;
  plsc_pkg::plsc_slice_cfg_s [3:0]       scfg = '0;
  logic                                  dual = 1'b0;
  logic [3:0][14:0]                      rin = '0;
  logic                                  creq = 1'b0;
  logic                                  slow = 1'b0;
  logic                                  cin;
  logic [3:0][5:0]                       rout;
  logic                                  cout;
  logic [15:0]                           tb_t [8];
  logic [3:0]                            ex0, n4;
  logic [1:0]                            a, b, bb;
  logic                                  c, d, e1, e3;
  logic [2:0]                            sum;
  int                                    err_count = 0;
  int                                    checks = 0;
  plsc_pkg::plsc_rip_e ops [4] = '{plsc_pkg::OP_ADD, plsc_pkg::OP_SUB, plsc_pkg::OP_ADDSUB, plsc_pkg::OP_COMPARE};

  always #25 clk_sys_in = ~clk_sys_in;
  plsc_logic_cluster u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_load_en_in(cfg_en),
    .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr), .cfg_data_in(cfg_data), .slice_cfg_in(scfg),
    .ram_dual_in(dual), .route_in(rin), .carry_in(cin), .route_out(rout), .carry_out(cout));
  plsc_carry_nbr u_nbr (.clk_sys_in(clk_sys_in), .carry_req_in(creq), .slow_in(slow), .carry_out(cin));

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic nx(input int n = 1);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Write strobe is left high so that writes can follow back to back.
  task automatic cfg_put(input logic [2:0] ad, input logic [15:0] dt, input logic en);
    nx();
    cfg_en = en;
    cfg_wr = 1'b1;
    cfg_addr = ad;
    cfg_data = dt;
  endtask
  // One low and one high phase of the local clock of slice s.
  task automatic tick(input int s);
    nx();
    rin[s][10] = 1'b0;
    nx();
    rin[s][10] = 1'b1;
    nx();
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hang cannot outlast this bound.
  initial begin
    repeat (20000) @(negedge clk_sys_in);
    err_count++;
    report_and_stop();
  end

  initial begin
    for (int k = 0; k < 8; k++) begin
      tb_t[k] = 16'h6A3C ^ {4{k[3:0]}};
    end
    nx(10);
    resetn_in = 1'b1;
    `CHK({cout, rout}, 25'h0000000)
    for (int k = 0; k < 8; k++) begin
      cfg_put(k[2:0], tb_t[k], 1'b1);
    end
    cfg_put(3'h0, 16'h0000, 1'b0);
    nx();
    cfg_wr = 1'b0;
    // Every code through every table; the local clock toggles to exercise capture.
    for (int n = 0; n < 16; n++) begin
      n4 = n[3:0];
      for (int s = 0; s < 4; s++) begin
        rin[s] = {2'b01, 1'b0, 1'b0, n4[0], n4[1], n4[0], ~n4, n4};
        ex0[s] = n4[0] ? tb_t[2*s+1][~n4] : tb_t[2*s][n4];
      end
      nx();
      e1 = n4[1] ? ex0[1] : ex0[0];
      e3 = n4[1] ? ex0[3] : ex0[2];
      for (int s = 0; s < 4; s++) begin
        `CHK({rout[s][4], rout[s][1:0]}, {ex0[s], tb_t[2*s+1][~n4], tb_t[2*s][n4]})
      end
      `CHK({rout[1][5], rout[2][5], rout[3][5]}, {e1, n4[1] ? e3 : e1, e3})
    end
    // Two-bit arithmetic on slice zero; other slices pass the carry on.
    scfg[0].mode = plsc_pkg::MODE_RIPPLE;
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 32; v++) begin
        a = v[1:0];
        b = v[3:2];
        d = v[4];
        c = (ops[i] == plsc_pkg::OP_COMPARE) | v[0];
        scfg[0].op = ops[i];
        rin[0] = {5'h00, d, 1'b0, 1'b0, 1'b0, b[1], a[1], 2'b00, b[0], a[0]};
        creq = c;
        bb = (ops[i] == plsc_pkg::OP_ADD || (ops[i] == plsc_pkg::OP_ADDSUB && !d)) ? b : ~b;
        sum = {1'b0, a} + {1'b0, bb} + {2'b00, c};
        nx();
        if (ops[i] == plsc_pkg::OP_COMPARE) begin
          `CHK({cout, rout[0][4], rout[0][1:0]}, {a >= b, a <= b, a != b, a >= b})
        end else begin
          `CHK({rout[0][5:4], cout, rout[0][1:0]}, {2'b00, sum})
        end
      end
    end
    // Fast carry: generate when A+B overflows, propagate when A+B is three.
    scfg[0].op = plsc_pkg::OP_ADD;
    scfg[0].fast_carry = 1'b1;
    rin[0] = 15'h0011;
    nx();
    `CHK(rout[0][5:4], 2'b10)
    rin[0] = 15'h0013;
    nx();
    `CHK(rout[0][5:4], 2'b01)
    scfg[0].fast_carry = 1'b0;
    // Counter: preload, count up with wrap, count down, clears and sets.
    slow = 1'b1;
    creq = 1'b1;
    scfg[0].op = plsc_pkg::OP_CNT_UP;
    rin[0] = 15'h6010;
    tick(0);
    `CHK(rout[0][3:2], 2'h2)
    rin[0][14] = 1'b0;
    tick(0);
    `CHK(rout[0][3:2], 2'h3)
    tick(0);
    `CHK(rout[0][3:2], 2'h0)
    scfg[0].op = plsc_pkg::OP_CNT_DN;
    creq = 1'b0;
    tick(0);
    `CHK(rout[0][3:2], 2'h3)
    scfg[0].sr_async = 1'b1;
    rin[0][12] = 1'b1;
    nx();
    `CHK(rout[0][3:2], 2'h0)
    scfg[0].sr_async = 1'b0;
    scfg[0].sr_set = 1'b1;
    nx();
    `CHK(rout[0][3:2], 2'h0)
    tick(0);
    `CHK(rout[0][3:2], 2'h3)
    rin[0][12] = 1'b0;
    rin[0][13] = 1'b0;
    tick(0);
    `CHK(rout[0][3:2], 2'h3)
    // Inverted clock captures on the falling edge; a latch follows while open.
    scfg[0].op = plsc_pkg::OP_CNT_UP;
    scfg[0].clk_neg = 1'b1;
    rin[0][13] = 1'b1;
    creq = 1'b1;
    nx(2);
    rin[0][10] = 1'b0;
    nx();
    `CHK(rout[0][3:2], 2'h0)
    rin[0][10] = 1'b1;
    nx();
    `CHK(rout[0][3:2], 2'h0)
    scfg[0].clk_neg = 1'b0;
    scfg[0].latch = 1'b1;
    nx();
    `CHK(rout[0][3:2], 2'h1)
    nx();
    `CHK(rout[0][3:2], 2'h2)
    // Memory of slices zero and one, addressed by slice two.
    scfg = '0;
    slow = 1'b0;
    creq = 1'b0;
    dual = 1'b1;
    rin = '0;
    for (int s = 0; s < 4; s++) begin
      scfg[s].mode = plsc_pkg::MODE_RAM;
    end
    rin[2][13] = 1'b1;
    for (int k = 0; k < 16; k++) begin
      n4 = k[3:0];
      rin[2][8:0] = {1'b1, n4 - 4'h1, n4};
      {rin[1][9], rin[1][8], rin[0][9], rin[0][8]} = n4 ^ 4'hA;
      tick(2);
      if (k > 0) begin
        `CHK({rout[1][1:0], rout[0][1:0]}, (n4 - 4'h1) ^ 4'hA)
      end
    end
    dual = 1'b0;
    rin[2][8] = 1'b0;
    rin[2][3:0] = 4'h5;
    rin[3][3:0] = 4'h9;
    nx();
    `CHK({rout[1][1:0], rout[0][1:0]}, 4'hF)
    `CHK(rout[3][0], tb_t[6][9])
    report_and_stop();
  end
endmodule
